// >>> hdl/cpcr_pkg.sv
// package: register map, field layout and reset values of the comparator pair block
package cpcr_pkg;

  // ********************************************************
  // register offsets (byte addresses)
  // ********************************************************
  localparam logic [7:0] OFS_CONF_A   = 8'h00;
  localparam logic [7:0] OFS_CONF_B   = 8'h04;
  localparam logic [7:0] OFS_WINDOW_CONFIG    = 8'h08;
  localparam logic [7:0] OFS_EVENT0_SOURCE_SELECT   = 8'h0c;
  localparam logic [7:0] OFS_EVENT1_SOURCE_SELECT   = 8'h10;
  localparam logic [7:0] OFS_SCALE_A  = 8'h14;
  localparam logic [7:0] OFS_SCALE_B  = 8'h18;
  localparam logic [7:0] OFS_EN_SET   = 8'h1c;
  localparam logic [7:0] OFS_EN_CLR   = 8'h20;
  localparam logic [7:0] OFS_SUT      = 8'h24;
  localparam logic [7:0] OFS_IRQ_SET  = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFS_EV_SET   = 8'h34;
  localparam logic [7:0] OFS_EV_CLR   = 8'h38;
  localparam logic [7:0] OFS_EV_MASK  = 8'h3c;
  localparam logic [7:0] OFS_STATUS   = 8'h40;
  localparam logic [7:0] OFS_STAT_CLR = 8'h44;
  localparam logic [7:0] OFS_VERSION  = 8'h48;

  // ********************************************************
  // reset values and writable masks
  // ********************************************************
  localparam logic [31:0] CONF_RESET   = 32'h8000_0000;
  localparam logic [31:0] ZERO_RESET   = 32'h0000_0000;
  localparam logic [31:0] CONF_WMASK   = 32'h9300_0f03 | 32'h000f_0000;
  localparam logic [31:0] WINDOW_CONFIG_WMASK  = 32'h0000_0f03;
  localparam logic [31:0] EVSRC_WMASK  = 32'h0000_000f;
  localparam logic [31:0] SCALE_WMASK  = 32'h0000_007f;
  localparam logic [31:0] SUT_WMASK    = 32'h0000_03ff;
  localparam logic [31:0] VERSION_DFLT = 32'h0000_0100;  // arbitrary value

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CONF_PAD_INHIBIT_BIT = 31;
  localparam int CONF_SPEED_BIT       = 28;
  localparam int CONF_HYST_LSB        = 24;
  localparam int CONF_NEG_LSB         = 16;
  localparam int SEL_LSB              = 8;
  localparam int IRQ_COND_LSB         = 0;
  localparam int EN_A_BIT             = 0;
  localparam int EN_B_BIT             = 1;
  localparam int EN_WF_BIT            = 2;
  localparam int EN_CMP_A_BIT         = 3;
  localparam int EN_CMP_B_BIT         = 4;
  localparam int NUM_EVENTS           = 5;

  // ********************************************************
  // encodings
  // ********************************************************
  typedef enum logic [1:0] {
    HYST_NONE,
    HYST_SMALL,
    HYST_HIGH
  } cpcr_hyst_t;

  localparam logic [1:0] COND_RISE   = 2'h0;
  localparam logic [1:0] COND_FALL   = 2'h1;
  localparam logic [1:0] COND_TOGGLE = 2'h2;
  localparam logic [3:0] EVSRC_LAST  = 4'h8;

endpackage : cpcr_pkg

// >>> hdl/cpcr_cmp_if.sv
// interface: per-comparator decoded configuration and result path
`timescale 1ns/1ps
interface cpcr_cmp_if;
  logic [1:0] cond;
  logic       out;
  logic       ready;
  logic       edge_hit;
  logic       rise;
  logic       fall;
  modport src (output cond, output out, output ready);
  modport det (input cond, input out, input ready, output edge_hit, output rise, output fall);
endinterface : cpcr_cmp_if

// >>> hdl/cpcr_edge_det.sv
// edge detector: interrupt condition per comparator or window output
`timescale 1ns/1ps
module cpcr_edge_det (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // comparator path
  cpcr_cmp_if.det   cmp
);
  logic prev_q;
  logic gated;

  assign gated    = cmp.out & cmp.ready;
  assign cmp.rise = gated & ~prev_q;
  assign cmp.fall = ~gated & prev_q;
  // code 11 raises nothing
  assign cmp.edge_hit = (cmp.cond == cpcr_pkg::COND_RISE)   ? cmp.rise :
                        (cmp.cond == cpcr_pkg::COND_FALL)   ? cmp.fall :
                        (cmp.cond == cpcr_pkg::COND_TOGGLE) ? (cmp.rise | cmp.fall) :
                        1'b0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= gated;
    end
  end
endmodule : cpcr_edge_det

// >>> hdl/cpcr_startup.sv
// startup timer: counts the programmed startup time after an enable
`timescale 1ns/1ps
module cpcr_startup (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       enable_i,
  input  wire logic [9:0] sut_i,
  // status
  output logic            ready_o
);
  logic [9:0] cnt_q;
  logic       ready_q;
  logic       en_q;

  assign ready_o = ready_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= 10'h000;
      ready_q <= 1'b0;
      en_q    <= 1'b0;
    end else begin
      en_q <= enable_i;
      if (!enable_i) begin
        cnt_q   <= 10'h000;
        ready_q <= 1'b0;
      end else if (!en_q) begin
        cnt_q <= 10'h000;
      end else if (!ready_q) begin
        if (cnt_q >= sut_i) begin
          ready_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end
endmodule : cpcr_startup

// >>> hdl/cpcr_top.sv
// top: register bank and configuration decode of the comparator pair
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps

module cpcr_top #(
  parameter logic [31:0] VERSION_VALUE = cpcr_pkg::VERSION_DFLT
) (
  // wishbone slave
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // analog comparator results
  input  wire logic        cmp_a_raw_i,
  input  wire logic        cmp_b_raw_i,
  // analog comparator controls
  output logic             cmp_a_enable_o,
  output logic             cmp_b_enable_o,
  output logic             cmp_a_high_speed_o,
  output logic             cmp_b_high_speed_o,
  output logic [1:0]       cmp_a_hysteresis_o,
  output logic [1:0]       cmp_b_hysteresis_o,
  output logic [3:0]       cmp_a_pos_sel_o,
  output logic [3:0]       cmp_a_neg_sel_o,
  output logic [3:0]       cmp_b_pos_sel_o,
  output logic [3:0]       cmp_b_neg_sel_o,
  output logic [6:0]       scale_a_o,
  output logic [6:0]       scale_b_o,
  // digital results
  output logic             comparator_a_pad_out_o,
  output logic             comparator_b_pad_out_o,
  output logic             comparator_a_pad_en_o,
  output logic             comparator_b_pad_en_o,
  output logic             window_out_o,
  // events and interrupt
  output logic [1:0]       event_o,
  output logic             irq_o
);

  // ********************************************************
  // registers
  // ********************************************************
  logic [31:0] conf_a_q;
  logic [31:0] conf_b_q;
  logic [31:0] window_config_q;
  logic [31:0] evsrc_q [2];
  logic [31:0] scale_a_q;
  logic [31:0] scale_b_q;
  logic [31:0] sut_q;
  logic [4:0]  enable_q;
  logic [4:0]  irq_mask_q;
  logic [1:0]  ev_mask_q;
  logic [4:0]  status_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] dat_q;
  logic [1:0]  event_q;

  // ********************************************************
  // bus decode
  // ********************************************************
  wire         req      = cyc_i & stb_i & ~ack_q & ~err_q;
  wire         all_lane = (sel_i == 4'hf);
  // writes land on the edge that samples ack, while the master still holds the request
  wire         wr_phase = cyc_i & stb_i & ack_q;
  wire         wr       = wr_phase & we_i & all_lane;  // partial lanes acked but dropped
  wire         hit_conf_a  = adr_i == cpcr_pkg::OFS_CONF_A;
  wire         hit_conf_b  = adr_i == cpcr_pkg::OFS_CONF_B;
  wire         hit_window_config   = adr_i == cpcr_pkg::OFS_WINDOW_CONFIG;
  wire         hit_ev0     = adr_i == cpcr_pkg::OFS_EVENT0_SOURCE_SELECT;
  wire         hit_ev1     = adr_i == cpcr_pkg::OFS_EVENT1_SOURCE_SELECT;
  wire         hit_scale_a = adr_i == cpcr_pkg::OFS_SCALE_A;
  wire         hit_scale_b = adr_i == cpcr_pkg::OFS_SCALE_B;
  wire         hit_en_set  = adr_i == cpcr_pkg::OFS_EN_SET;
  wire         hit_en_clr  = adr_i == cpcr_pkg::OFS_EN_CLR;
  wire         hit_sut     = adr_i == cpcr_pkg::OFS_SUT;
  wire         hit_irq_set = adr_i == cpcr_pkg::OFS_IRQ_SET;
  wire         hit_irq_clr = adr_i == cpcr_pkg::OFS_IRQ_CLR;
  wire         hit_irq_msk = adr_i == cpcr_pkg::OFS_IRQ_MASK;
  wire         hit_ev_set  = adr_i == cpcr_pkg::OFS_EV_SET;
  wire         hit_ev_clr  = adr_i == cpcr_pkg::OFS_EV_CLR;
  wire         hit_ev_msk  = adr_i == cpcr_pkg::OFS_EV_MASK;
  wire         hit_status  = adr_i == cpcr_pkg::OFS_STATUS;
  wire         hit_st_clr  = adr_i == cpcr_pkg::OFS_STAT_CLR;
  wire         hit_version = adr_i == cpcr_pkg::OFS_VERSION;
  wire         mapped   = hit_conf_a | hit_conf_b | hit_window_config | hit_ev0 | hit_ev1 | hit_scale_a
                        | hit_scale_b | hit_en_set | hit_en_clr | hit_sut | hit_irq_set
                        | hit_irq_clr | hit_irq_msk | hit_ev_set | hit_ev_clr | hit_ev_msk
                        | hit_status | hit_st_clr | hit_version;
  wire  [4:0]  wr5      = dat_i[4:0];
  wire  [1:0]  wr2      = dat_i[1:0];

  // ********************************************************
  // comparator paths
  // ********************************************************
  cpcr_cmp_if path_a ();
  cpcr_cmp_if path_b ();
  cpcr_cmp_if path_w ();

  logic rdy_a;
  logic rdy_b;
  wire  win_mode = enable_q[cpcr_pkg::EN_WF_BIT];
  wire  run_a    = enable_q[cpcr_pkg::EN_A_BIT];
  wire  run_b    = enable_q[cpcr_pkg::EN_B_BIT];

  // each enable restarts the timer, so a disable/enable pair pays the full startup again
  cpcr_startup u_start_a (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (run_a),
    .sut_i    (sut_q[9:0]),
    .ready_o  (rdy_a)
  );
  cpcr_startup u_start_b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (run_b),
    .sut_i    (sut_q[9:0]),
    .ready_o  (rdy_b)
  );

  // result held low until ready and comparison enabled
  wire  res_a = cmp_a_raw_i & rdy_a & enable_q[cpcr_pkg::EN_CMP_A_BIT];
  wire  res_b = cmp_b_raw_i & rdy_b & enable_q[cpcr_pkg::EN_CMP_B_BIT];
  wire  rdy_w = rdy_a & rdy_b & win_mode;
  // a compares vip_a (upper) to common, b compares common to vin_b (lower)
  wire  res_w = res_a & res_b & rdy_w;

  assign path_a.cond  = conf_a_q[cpcr_pkg::IRQ_COND_LSB +: 2];
  assign path_a.out   = res_a;
  assign path_a.ready = rdy_a;
  assign path_b.cond  = conf_b_q[cpcr_pkg::IRQ_COND_LSB +: 2];
  assign path_b.out   = res_b;
  assign path_b.ready = rdy_b;
  assign path_w.cond  = window_config_q[cpcr_pkg::IRQ_COND_LSB +: 2];
  assign path_w.out   = res_w;
  assign path_w.ready = rdy_w;

  cpcr_edge_det u_det_a (.clk_i(clk_i), .rst_i(rst_i), .cmp(path_a));
  cpcr_edge_det u_det_b (.clk_i(clk_i), .rst_i(rst_i), .cmp(path_b));
  cpcr_edge_det u_det_w (.clk_i(clk_i), .rst_i(rst_i), .cmp(path_w));

  // startup-done pulses for status
  logic rdy_a_q;
  logic rdy_b_q;
  wire  start_a_done = rdy_a & ~rdy_a_q;
  wire  start_b_done = rdy_b & ~rdy_b_q;
  // window condition only counts while the window function runs
  wire  win_hit      = path_w.edge_hit & win_mode;
  wire  [4:0] hw_set = {start_b_done, start_a_done, win_hit, path_b.edge_hit, path_a.edge_hit};

  // ********************************************************
  // event source selection
  // ********************************************************
  wire  [1:0] ev_hit;
  // source codes above the last one select nothing
  for (genvar g = 0; g < 2; g++) begin : g_event
    wire [3:0] src = evsrc_q[g][3:0];
    wire [8:0] pick = {path_w.rise | path_w.fall, path_w.fall, path_w.rise,
                       path_b.rise | path_b.fall, path_b.fall, path_b.rise,
                       path_a.rise | path_a.fall, path_a.fall, path_a.rise};
    assign ev_hit[g] = (src <= cpcr_pkg::EVSRC_LAST) ? pick[src] : 1'b0;
  end

  // ********************************************************
  // configuration outputs
  // ********************************************************
  function automatic logic [1:0] hyst_decode(input logic [1:0] code);
    cpcr_pkg::cpcr_hyst_t h;
    h = cpcr_pkg::HYST_NONE;
    if (code == 2'h1) begin
      h = cpcr_pkg::HYST_SMALL;
    end else if (code == 2'h2) begin
      h = cpcr_pkg::HYST_HIGH;
    end
    return h;
  endfunction : hyst_decode

  assign cmp_a_enable_o     = run_a;
  assign cmp_b_enable_o     = run_b;
  assign cmp_a_high_speed_o = conf_a_q[cpcr_pkg::CONF_SPEED_BIT];
  assign cmp_b_high_speed_o = conf_b_q[cpcr_pkg::CONF_SPEED_BIT];
  assign cmp_a_hysteresis_o = hyst_decode(conf_a_q[cpcr_pkg::CONF_HYST_LSB +: 2]);
  assign cmp_b_hysteresis_o = hyst_decode(conf_b_q[cpcr_pkg::CONF_HYST_LSB +: 2]);
  assign cmp_a_pos_sel_o    = conf_a_q[cpcr_pkg::SEL_LSB +: 4];
  assign cmp_b_neg_sel_o    = conf_b_q[cpcr_pkg::CONF_NEG_LSB +: 4];
  // common select takes over the shared inputs in window mode
  assign cmp_a_neg_sel_o    = win_mode ? window_config_q[cpcr_pkg::SEL_LSB +: 4]
                                       : conf_a_q[cpcr_pkg::CONF_NEG_LSB +: 4];
  assign cmp_b_pos_sel_o    = win_mode ? window_config_q[cpcr_pkg::SEL_LSB +: 4]
                                       : conf_b_q[cpcr_pkg::SEL_LSB +: 4];
  assign scale_a_o          = scale_a_q[6:0];
  assign scale_b_o          = scale_b_q[6:0];
  assign comparator_a_pad_out_o = res_a;
  assign comparator_b_pad_out_o = res_b;
  assign comparator_a_pad_en_o  = ~conf_a_q[cpcr_pkg::CONF_PAD_INHIBIT_BIT];
  assign comparator_b_pad_en_o  = ~conf_b_q[cpcr_pkg::CONF_PAD_INHIBIT_BIT];
  assign window_out_o       = res_w;
  assign event_o            = event_q;
  // level request: high while any unmasked sticky bit stands
  assign irq_o              = |(status_q & irq_mask_q);
  assign ack_o              = ack_q;
  assign err_o              = err_q;
  assign dat_o              = dat_q;

  // ********************************************************
  // read mux
  // ********************************************************
  // live bits above the sticky ones: both ready, results a/b/window, window ready
  wire        both_rdy = rdy_a & rdy_b;
  wire [4:0]  live5    = {rdy_w, res_w, res_b, res_a, both_rdy};
  wire [31:0] rd_live  = {27'h000_0000, live5};
  wire [31:0] rd_data =
      hit_conf_a  ? conf_a_q :
      hit_conf_b  ? conf_b_q :
      hit_window_config   ? window_config_q :
      hit_ev0     ? evsrc_q[0] :
      hit_ev1     ? evsrc_q[1] :
      hit_scale_a ? scale_a_q :
      hit_scale_b ? scale_b_q :
      hit_sut     ? sut_q :
      hit_irq_msk ? {27'h000_0000, irq_mask_q} :
      hit_ev_msk  ? {30'h0000_0000, ev_mask_q} :
      hit_status  ? {rd_live[26:0], status_q} :
      hit_version ? VERSION_VALUE :
      cpcr_pkg::ZERO_RESET;                       // write-only reads zero

  // ********************************************************
  // bus handshake
  // ********************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= cpcr_pkg::ZERO_RESET;
    end else begin
      // answer one cycle after the take; req is blocked while ack or err stands
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
      dat_q <= (req & ~we_i) ? rd_data : cpcr_pkg::ZERO_RESET;
    end
  end

  // ********************************************************
  // configuration registers
  // ********************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conf_a_q   <= cpcr_pkg::CONF_RESET;
      conf_b_q   <= cpcr_pkg::CONF_RESET;
      window_config_q    <= cpcr_pkg::ZERO_RESET;
      evsrc_q[0] <= cpcr_pkg::ZERO_RESET;
      evsrc_q[1] <= cpcr_pkg::ZERO_RESET;
      scale_a_q  <= cpcr_pkg::ZERO_RESET;
      scale_b_q  <= cpcr_pkg::ZERO_RESET;
      sut_q      <= cpcr_pkg::ZERO_RESET;
    end else if (wr) begin
      // reserved bits masked off so they read zero
      if (hit_conf_a)  conf_a_q   <= dat_i & cpcr_pkg::CONF_WMASK;
      if (hit_conf_b)  conf_b_q   <= dat_i & cpcr_pkg::CONF_WMASK;
      if (hit_window_config)   window_config_q    <= dat_i & cpcr_pkg::WINDOW_CONFIG_WMASK;
      if (hit_ev0)     evsrc_q[0] <= dat_i & cpcr_pkg::EVSRC_WMASK;
      if (hit_ev1)     evsrc_q[1] <= dat_i & cpcr_pkg::EVSRC_WMASK;
      if (hit_scale_a) scale_a_q  <= dat_i & cpcr_pkg::SCALE_WMASK;
      if (hit_scale_b) scale_b_q  <= dat_i & cpcr_pkg::SCALE_WMASK;
      if (hit_sut)     sut_q      <= dat_i & cpcr_pkg::SUT_WMASK;
    end
  end

  // ********************************************************
  // enables and masks, set/clear pairs
  // ********************************************************
  // window enable forces both comparators and comparisons on; window disable drops comparisons
  wire       en_wr  = wr & hit_en_set;
  wire       dis_wr = wr & hit_en_clr;
  wire       wf_bit = wr5[cpcr_pkg::EN_WF_BIT];
  wire [4:0] en_set = en_wr  ? (wf_bit ? 5'h1f : wr5) : 5'h00;
  wire [4:0] en_clr = dis_wr ? (wf_bit ? (wr5 | 5'h18) : wr5) : 5'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q   <= 5'h00;
      irq_mask_q <= 5'h00;
      ev_mask_q  <= 2'h0;
    end else begin
      enable_q   <= (enable_q & ~en_clr) | en_set;
      if (wr & hit_irq_set) irq_mask_q <= irq_mask_q | wr5;
      if (wr & hit_irq_clr) irq_mask_q <= irq_mask_q & ~wr5;
      if (wr & hit_ev_set)  ev_mask_q  <= ev_mask_q | wr2;
      if (wr & hit_ev_clr)  ev_mask_q  <= ev_mask_q & ~wr2;
    end
  end

  // ********************************************************
  // status and events
  // ********************************************************
  wire [4:0] st_clr = (wr & hit_st_clr) ? wr5 : 5'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 5'h00;
      rdy_a_q  <= 1'b0;
      rdy_b_q  <= 1'b0;
      event_q  <= 2'h0;
    end else begin
      // a fresh event beats a clear in the same cycle
      status_q <= (status_q & ~st_clr) | hw_set;
      rdy_a_q  <= rdy_a;
      rdy_b_q  <= rdy_b;
      // registered, so an event pulse trails its edge by one cycle
      event_q  <= ev_hit & ev_mask_q;
    end
  end

endmodule : cpcr_top

// >>> dv/cpcr_properties.sv
// checker: bus timing and decode properties of the comparator pair block
`timescale 1ns/1ps
module cpcr_properties (
  // bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // decode
  input wire logic        cmp_a_enable_o,
  input wire logic        cmp_b_enable_o,
  input wire logic        cmp_a_high_speed_o,
  input wire logic [1:0]  cmp_b_hysteresis_o,
  input wire logic [3:0]  cmp_b_neg_sel_o,
  input wire logic        comparator_a_pad_en_o,
  input wire logic        comparator_a_pad_out_o,
  input wire logic        window_out_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take   = cyc_i && stb_i && !ack_o && !err_o;
  wire mapped = adr_i <= 8'h48 && adr_i[1:0] == 2'b00;
  wire wr_a   = ack_o && we_i && sel_i == 4'hf && adr_i == 8'h00;
  wire wr_b   = ack_o && we_i && sel_i == 4'hf && adr_i == 8'h04;
  wire rd_ack = ack_o && !we_i;
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_ACK_MAPPED: assert property (take && mapped |=> ack_o && !err_o) else $error("no ack");
  AST_ERR_UNMAPPED: assert property (take && !mapped |=> err_o && !ack_o) else $error("no err");
  AST_PAD_INHIBIT: assert property (wr_a |=> comparator_a_pad_en_o == !$past(dat_i[31]))
    else $error("pad enable");
  AST_SPEED: assert property (wr_a |=> cmp_a_high_speed_o == $past(dat_i[28])) else $error("speed");
  AST_HYST: assert property (wr_b |=> cmp_b_hysteresis_o ==
    (($past(dat_i[25:24]) == 2'b11) ? 2'b00 : $past(dat_i[25:24]))) else $error("hysteresis");
  AST_NEG_SEL: assert property (wr_b |=> cmp_b_neg_sel_o == $past(dat_i[19:16])) else $error("neg sel");
  AST_WO_READ: assert property (rd_ack && adr_i == 8'h1c |-> dat_o == 32'h0) else $error("wo read");
  AST_RSVD: assert property (rd_ack && adr_i == 8'h08 |-> dat_o[31:12] == 20'h0 && dat_o[7:2] == 6'h0)
    else $error("reserved bits");
  AST_IRQ_MASK: assert property (rd_ack && adr_i == 8'h30 && dat_o == 32'h0 |-> !irq_o)
    else $error("irq masked");
  AST_WIN_READY: assert property (window_out_o |-> cmp_a_enable_o && cmp_b_enable_o)
    else $error("window out");
  AST_RESULT_GATE: assert property (comparator_a_pad_out_o |-> cmp_a_enable_o) else $error("result");
  cover property (err_o);
  cover property (irq_o);
  cover property (wr_b);
endmodule : cpcr_properties
bind cpcr_top cpcr_properties u_cpcr_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .cmp_a_enable_o(cmp_a_enable_o), .cmp_b_enable_o(cmp_b_enable_o), .cmp_a_high_speed_o(cmp_a_high_speed_o),
  .cmp_b_hysteresis_o(cmp_b_hysteresis_o), .cmp_b_neg_sel_o(cmp_b_neg_sel_o), .irq_o(irq_o),
  .comparator_a_pad_en_o(comparator_a_pad_en_o), .comparator_a_pad_out_o(comparator_a_pad_out_o),
  .window_out_o(window_out_o));

// >>> dv/cpcr_tb_top.sv
// testbench: register map, decode and interrupt of the comparator pair block
`timescale 1ns/1ps
module cpcr_tb_top;
  // ********
  // signals
  // ********
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, raw_a = 0, raw_b = 0, last_err;
  logic [7:0]  adr_i = 0;
  logic [3:0]  sel_i = 0, a_ns, b_ps;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic        ack_o, err_o, b_hs, b_pe, a_po, irq_o, a_pe, w_out;
  logic [1:0]  b_hy;
  int          n_fail = 0, compares = 0, cycles = 0;
  // write address 8'hff means read only
  typedef struct { logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex; } cpcr_row_t;
  cpcr_row_t rows [17] = '{'{8'hff, 0, 8'h00, 32'h8000_0000}, '{8'hff, 0, 8'h04, 32'h8000_0000},
    '{8'hff, 0, 8'h08, 0}, '{8'hff, 0, 8'h0c, 0}, '{8'hff, 0, 8'h24, 0}, '{8'hff, 0, 8'h30, 0},
    '{8'hff, 0, 8'h40, 0}, '{8'hff, 0, 8'h48, cpcr_pkg::VERSION_DFLT},
    '{8'h00, 32'hffff_ffff, 8'h00, 32'h930f_0f03}, '{8'h04, 32'h1234_5678, 8'h04, 32'h1204_0600},
    '{8'h08, 32'hffff_ffff, 8'h08, 32'h0000_0f03}, '{8'h0c, 32'hffff_ffff, 8'h0c, 32'h0000_000f},
    '{8'h28, 32'hffff_ffff, 8'h30, 32'h0000_001f}, '{8'h2c, 32'h0000_0003, 8'h30, 32'h0000_001c},
    '{8'h34, 32'hffff_ffff, 8'h3c, 32'h0000_0003}, '{8'h1c, 32'hffff_ffff, 8'h1c, 0},
    '{8'h48, 0, 8'h48, cpcr_pkg::VERSION_DFLT}};
  cpcr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .cmp_a_raw_i(raw_a),
    .cmp_b_raw_i(raw_b), .cmp_a_enable_o(), .cmp_b_enable_o(), .cmp_a_high_speed_o(), .cmp_b_high_speed_o(b_hs),
    .cmp_a_hysteresis_o(), .cmp_b_hysteresis_o(b_hy), .cmp_a_pos_sel_o(), .cmp_a_neg_sel_o(a_ns),
    .cmp_b_pos_sel_o(b_ps), .cmp_b_neg_sel_o(), .scale_a_o(), .scale_b_o(), .comparator_a_pad_out_o(a_po),
    .comparator_b_pad_out_o(), .comparator_a_pad_en_o(a_pe), .comparator_b_pad_en_o(b_pe), .window_out_o(w_out),
    .event_o(), .irq_o(irq_o));
  initial forever #10 clk_i = ~clk_i;
  // a hung handshake ends here
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    compares++;
    if (seen !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d = 0, input logic [3:0] s = 4'hf);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (!(ack_o || err_o)) @(posedge clk_i);
    rd = dat_o;
    last_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // ********
  // tests
  // ********
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].wa != 8'hff) wb(1, rows[i].wa, rows[i].wd);
      wb(0, rows[i].ra);
      chk("register", rd, rows[i].ex);
    end
    $display("test register map done");
    wb(0, 8'h80);
    chk("unmapped err", last_err, 1);
    wb(1, 8'h08, 0, 4'h1);
    wb(0, 8'h08);
    chk("partial lanes", rd, 32'h0000_0f03);
    for (int c = 0; c < 4; c++) begin
      wb(1, 8'h04, {3'b100, c[0], 2'b00, c[1:0], 24'h00_0000});
      chk("hysteresis", b_hy, (c == 3) ? 0 : c);
      chk("speed", b_hs, c[0]);
      chk("pad inhibit", b_pe, 0);
    end
    $display("test decode done");
    wb(1, 8'h24, 4);
    wb(1, 8'h20, 32'h0000_001f);
    wb(1, 8'h44, 32'h0000_001f);
    wb(1, 8'h1c, 32'h0000_001b);
    raw_a <= 1'b1;
    wb(0, 8'h40);
    chk("not ready", rd[3], 0);
    chk("result gated", a_po, 0);
    raw_a <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(0, 8'h40);
    chk("ready a", rd[3], 1);
    wb(1, 8'h2c, 32'h0000_001f);
    wb(1, 8'h28, 1);
    for (int c = 0; c < 4; c++) begin
      wb(1, 8'h00, c);
      wb(1, 8'h44, 32'h0000_001f);
      raw_a <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb(0, 8'h40);
      chk("rise", rd[0], c == 0 || c == 2);
      chk("irq", irq_o, c == 0 || c == 2);
      chk("pad out", a_po, 1);
      chk("pad enable", a_pe, 1);
      wb(1, 8'h44, 1);
      chk("irq clear", irq_o, 0);
      raw_a <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(0, 8'h40);
      chk("fall", rd[0], c == 1 || c == 2);
    end
    wb(1, 8'h00, 2);
    raw_a <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1, 8'h2c, 1);
    chk("irq masked", irq_o, 0);
    wb(0, 8'h40);
    chk("status kept", rd[0], 1);
    $display("test interrupt done");
    wb(1, 8'h00, 32'h0009_0000);
    wb(1, 8'h08, 32'h0000_0500);
    raw_b <= 1'b1;
    wb(1, 8'h1c, 32'h0000_0004);
    chk("a neg window", a_ns, 5);
    chk("b pos window", b_ps, 5);
    chk("window out", w_out, 1);
    wb(1, 8'h20, 32'h0000_0004);
    chk("window off", w_out, 0);
    chk("a neg normal", a_ns, 9);
    chk("b pos normal", b_ps, 0);
    $display("test window done");
    stop_test();
  end
endmodule : cpcr_tb_top
